// ===== oti_trim_irq.sv
// frequency trim sequencer, register port and two active-low irq pins
// assumes time fields show the new value while sec_tick is high
`default_nettype none

module oti_trim_irq
	import oti_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata_q,
	// timekeeping view
	input wire logic sec_tick,
	input wire oti_time_s time_now,
	input wire logic tick_128,
	// correction towards the counters
	output logic corr_add_q,
	output logic corr_sub_q,
	output logic [10:0] corr_clocks_q,
	// irq_out_a pin, open-drain
	output logic irq_out_a_o_q,
	output logic irq_out_a_oe_n_q,
	// stamp_pin carrying irq_out_b, push-pull
	output logic stamp_pin_o_q,
	output logic stamp_pin_oe_n_q,
	// system interrupt
	output logic sys_irq_q
);
	// -----------------------------------------------------------------
	// registers
	// -----------------------------------------------------------------
	logic [7:0] trim_q;
	logic [7:0] osc_ctrl_q;
	logic [7:0] sel_a_q;
	logic [7:0] sel_b_q;
	logic [7:0] pin_cfg_q;
	logic [ST_W-1:0] status_q;
	logic [ST_W-1:0] status_d;
	logic [ST_W-1:0] mask_q;
	logic [7:0] rdata_d;

	// sequencer state
	oti_seq_e seq_q;
	oti_seq_e seq_d;
	logic [7:0] count_q;
	logic [7:0] count_d;
	logic [7:0] mag_q;
	logic [7:0] mag_d;
	logic sign_q;
	logic sign_d;
	logic rate_q;
	logic rate_d;

	// -----------------------------------------------------------------
	// register decode
	// -----------------------------------------------------------------
	wire wr_trim = reg_wr && reg_addr == ADDR_FREQ_TRIM;
	wire wr_osc = reg_wr && reg_addr == ADDR_OSC_CTRL;
	wire wr_sel_a = reg_wr && reg_addr == ADDR_IRQ_A_SEL;
	wire wr_sel_b = reg_wr && reg_addr == ADDR_IRQ_B_SEL;
	wire wr_pin = reg_wr && reg_addr == ADDR_PIN_CFG;
	wire wr_status = reg_wr && reg_addr == ADDR_IRQ_STATUS;
	wire wr_mask = reg_wr && reg_addr == ADDR_IRQ_MASK;

	// field extraction
	wire rate_sel = osc_ctrl_q[BIT_RATE_SEL];
	wire trim_irq_en_a = sel_a_q[BIT_TRIM_IRQ_EN];
	wire trim_irq_en_b = sel_b_q[BIT_TRIM_IRQ_EN];
	wire [1:0] irq_a_pin_cfg = pin_cfg_q[PIN_A_LSB +: 2];
	wire [1:0] stamp_pin_cfg = pin_cfg_q[PIN_B_LSB +: 2];

	// read mux, unmapped reads zero
	assign rdata_d =
		(reg_addr == ADDR_FREQ_TRIM) ? trim_q :
		(reg_addr == ADDR_OSC_CTRL) ? osc_ctrl_q :
		(reg_addr == ADDR_IRQ_A_SEL) ? sel_a_q :
		(reg_addr == ADDR_IRQ_B_SEL) ? sel_b_q :
		(reg_addr == ADDR_PIN_CFG) ? pin_cfg_q :
		(reg_addr == ADDR_IRQ_STATUS) ? {5'h00, status_q} :
		(reg_addr == ADDR_IRQ_MASK) ? {5'h00, mask_q} : RST_BYTE;

	// software-held registers
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			trim_q <= RST_BYTE;
			osc_ctrl_q <= RST_BYTE;
			sel_a_q <= RST_BYTE;
			sel_b_q <= RST_BYTE;
			pin_cfg_q <= RST_BYTE;
			mask_q <= '0;
		end else begin
			if (wr_trim) trim_q <= reg_wdata;
			if (wr_osc) osc_ctrl_q <= reg_wdata;
			if (wr_sel_a) sel_a_q <= reg_wdata;
			if (wr_sel_b) sel_b_q <= reg_wdata;
			if (wr_pin) pin_cfg_q <= reg_wdata;
			if (wr_mask) mask_q <= reg_wdata[ST_W-1:0];
		end
	end

	// read data one cycle after the strobe
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata_q <= RST_BYTE;
		end else begin
			reg_rdata_q <= reg_rd ? rdata_d : RST_BYTE;
		end
	end

	// -----------------------------------------------------------------
	// schedule events
	// -----------------------------------------------------------------
	// trim magnitude; -128 gives 128, which still fits eight bits
	wire trim_neg = trim_q[7];
	wire [7:0] trim_mag = trim_neg ? 8'(-trim_q) : trim_q;

	// new minute is the second counter wrapping to 00
	wire new_minute = sec_tick && time_now.sec == POS_ZERO;
	// normal trigger: minute 00 of every fourth hour
	wire trig_normal = new_minute && time_now.min == POS_ZERO
		&& time_now.hour[1:0] == HOUR_MOD4_ZERO;
	// fast trigger: second 00 of every eighth minute
	wire trig_fast = new_minute && time_now.min[2:0] == MIN_MOD8_ZERO;
	wire trig = rate_sel ? trig_fast : trig_normal;
	wire start = seq_q == SEQ_IDLE && trig && trim_mag != MAG_ZERO;

	// a running sequence steps each minute or each second;
	// counting on past 59 rolls into the next hour or minute by itself
	wire unit_evt = rate_q ? sec_tick : new_minute;
	wire step = seq_q == SEQ_RUN && unit_evt;
	wire trim_evt = start || step;
	wire evt_sign = start ? trim_neg : sign_q;
	wire evt_rate = start ? rate_sel : rate_q;
	wire [7:0] evt_mag = start ? trim_mag : mag_q;
	wire [7:0] evt_count = start ? MAG_ONE : count_q + MAG_ONE;
	wire seq_last = evt_count == evt_mag;

	// -----------------------------------------------------------------
	// sequencer
	// -----------------------------------------------------------------
	always_comb begin
		seq_d = seq_q;
		count_d = count_q;
		mag_d = mag_q;
		sign_d = sign_q;
		rate_d = rate_q;
		case (seq_q)
			SEQ_IDLE: begin
				if (start) begin
					mag_d = trim_mag;
					sign_d = trim_neg;
					rate_d = rate_sel;
					count_d = MAG_ONE;
					seq_d = seq_last ? SEQ_IDLE : SEQ_RUN;
				end
			end
			SEQ_RUN: begin
				if (step) begin
					count_d = evt_count;
					seq_d = seq_last ? SEQ_IDLE : SEQ_RUN;
				end
			end
			default: begin
				seq_d = SEQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			seq_q <= SEQ_IDLE;
			count_q <= MAG_ZERO;
			mag_q <= MAG_ZERO;
			sign_q <= 1'b0;
			rate_q <= 1'b0;
		end else begin
			seq_q <= seq_d;
			count_q <= count_d;
			mag_q <= mag_d;
			sign_q <= sign_d;
			rate_q <= rate_d;
		end
	end

	// -----------------------------------------------------------------
	// correction pulses to the counters
	// -----------------------------------------------------------------
	// positive trim adds clocks, negative removes them
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			corr_add_q <= 1'b0;
			corr_sub_q <= 1'b0;
			corr_clocks_q <= '0;
		end else begin
			corr_add_q <= trim_evt && !evt_sign;
			corr_sub_q <= trim_evt && evt_sign;
			corr_clocks_q <= evt_rate ? CLKS_FAST : CLKS_NORMAL;
		end
	end

	// -----------------------------------------------------------------
	// irq pulses, one generator per output
	// -----------------------------------------------------------------
	logic act_a;
	logic act_b;

	oti_irq_pulse u_pulse_a (
		.clk(clk),
		.sys_rst(sys_rst),
		.event_in(trim_evt && trim_irq_en_a),
		.tick_128(tick_128),
		.active_q(act_a)
	);

	oti_irq_pulse u_pulse_b (
		.clk(clk),
		.sys_rst(sys_rst),
		.event_in(trim_evt && trim_irq_en_b),
		.tick_128(tick_128),
		.active_q(act_b)
	);

	// pin drivers, active low and only in the right pin mode
	wire a_mode_ok = irq_a_pin_cfg == IRQ_A_CFG_INT;
	wire b_mode_ok = stamp_pin_cfg == STAMP_CFG_INT;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_out_a_o_q <= 1'b0;
			irq_out_a_oe_n_q <= 1'b1;
			stamp_pin_o_q <= 1'b1;
			stamp_pin_oe_n_q <= 1'b1;
		end else begin
			irq_out_a_o_q <= 1'b0;
			irq_out_a_oe_n_q <= !(a_mode_ok && act_a);
			stamp_pin_o_q <= !act_b;
			stamp_pin_oe_n_q <= !b_mode_ok;
		end
	end

	// -----------------------------------------------------------------
	// system interrupt status and mask
	// -----------------------------------------------------------------
	wire [ST_W-1:0] st_set = {trim_evt && seq_last, trim_evt && evt_sign,
		trim_evt && !evt_sign};
	wire [ST_W-1:0] st_clr = wr_status ? reg_wdata[ST_W-1:0] : '0;
	// a set in the same cycle as its clear wins
	assign status_d = (status_q & ~st_clr) | st_set;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			status_q <= '0;
			sys_irq_q <= 1'b0;
		end else begin
			status_q <= status_d;
			sys_irq_q <= |(status_d & mask_q);
		end
	end

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	start_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
		(seq_q == SEQ_IDLE && trig && trim_mag != MAG_ZERO)
		|=> (corr_add_q || corr_sub_q))
		else $error("trigger gave no correction");

	zero_trim_a: assert property (@(posedge clk) disable iff (sys_rst)
		(seq_q == SEQ_IDLE && trim_q == RST_BYTE) |=> !(corr_add_q || corr_sub_q))
		else $error("correction with zero trim");

	count_bound_a: assert property (@(posedge clk) disable iff (sys_rst)
		seq_q == SEQ_RUN |-> count_q < mag_q)
		else $error("sequence overran magnitude");

	sign_dir_a: assert property (@(posedge clk) disable iff (sys_rst)
		corr_sub_q |-> $past(evt_sign) && !corr_add_q)
		else $error("correction direction wrong");

	step_size_a: assert property (@(posedge clk) disable iff (sys_rst)
		(corr_add_q || corr_sub_q) |->
		corr_clocks_q == ($past(evt_rate) ? CLKS_FAST : CLKS_NORMAL))
		else $error("correction size wrong");

	fast_step_a: assert property (@(posedge clk) disable iff (sys_rst)
		(seq_q == SEQ_RUN && rate_q && sec_tick) |=> (corr_add_q || corr_sub_q))
		else $error("fast step missed a second");

	irq_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(act_a) |-> $past(trim_evt && trim_irq_en_a))
		else $error("irq a pulse without enabled event");

	pin_a_mode_a: assert property (@(posedge clk) disable iff (sys_rst)
		!irq_out_a_oe_n_q |-> $past(a_mode_ok && act_a) && !irq_out_a_o_q)
		else $error("irq a driven in wrong mode");

	stamp_mode_a: assert property (@(posedge clk) disable iff (sys_rst)
		!stamp_pin_oe_n_q |-> $past(b_mode_ok))
		else $error("stamp pin driven in wrong mode");

	// sequencer checks: pulses only on schedule, end on the last one
	seq_end_a: assert property (@(posedge clk) disable iff (sys_rst)
		(trim_evt && seq_last) |=> seq_q == SEQ_IDLE)
		else $error("sequence ran past its last pulse");

	normal_step_a: assert property (@(posedge clk) disable iff (sys_rst)
		(seq_q == SEQ_RUN && !rate_q && new_minute) |=> (corr_add_q || corr_sub_q))
		else $error("normal step missed a minute");

	run_retrig_a: assert property (@(posedge clk) disable iff (sys_rst)
		(seq_q == SEQ_RUN && !unit_evt) |=> !(corr_add_q || corr_sub_q))
		else $error("correction between steps");

	idle_quiet_a: assert property (@(posedge clk) disable iff (sys_rst)
		(seq_q == SEQ_IDLE && !start) |=> !(corr_add_q || corr_sub_q))
		else $error("correction without trigger");

	neg_sub_a: assert property (@(posedge clk) disable iff (sys_rst)
		(start && trim_neg) |=> (corr_sub_q && !corr_add_q))
		else $error("negative trim did not remove clocks");

	// irq and pin checks: pulse starts on the event, stamp pin low only on irq
	irq_a_start_a: assert property (@(posedge clk) disable iff (sys_rst)
		(trim_evt && trim_irq_en_a) |=> act_a)
		else $error("irq a pulse did not start");

	irq_b_start_a: assert property (@(posedge clk) disable iff (sys_rst)
		(trim_evt && trim_irq_en_b) |=> act_b)
		else $error("irq b pulse did not start");

	irq_gate_b_a: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(act_b) |-> $past(trim_evt && trim_irq_en_b))
		else $error("irq b pulse without enabled event");

	stamp_low_a: assert property (@(posedge clk) disable iff (sys_rst)
		(!stamp_pin_oe_n_q && !stamp_pin_o_q) |-> $past(act_b && b_mode_ok))
		else $error("stamp pin low without irq");
endmodule : oti_trim_irq

`default_nettype wire

// ===== oti_pkg.sv
// constants, types and register map of the frequency trim and irq output block
// assumes a single 40 MHz clock and timekeeping counters outside this block
`default_nettype none

package oti_pkg;
	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_FREQ_TRIM = 8'h24;
	localparam logic [7:0] ADDR_OSC_CTRL = 8'h25;
	localparam logic [7:0] ADDR_IRQ_A_SEL = 8'h29;
	localparam logic [7:0] ADDR_IRQ_B_SEL = 8'h2a;
	localparam logic [7:0] ADDR_PIN_CFG = 8'h30;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h31;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h32;

	// reset values and field positions
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam int BIT_RATE_SEL = 6;
	localparam int BIT_TRIM_IRQ_EN = 5;
	localparam int PIN_A_LSB = 0;
	localparam int PIN_B_LSB = 2;
	localparam logic [1:0] IRQ_A_CFG_INT = 2'h0;
	localparam logic [1:0] STAMP_CFG_INT = 2'h1;
	localparam int ST_ADD = 0;
	localparam int ST_SUB = 1;
	localparam int ST_DONE = 2;
	localparam int ST_W = 3;

	// ----------------------------------------------------------------
	// schedule constants
	// ----------------------------------------------------------------
	localparam logic [5:0] POS_ZERO = 6'h00;
	localparam logic [1:0] HOUR_MOD4_ZERO = 2'h0;
	localparam logic [2:0] MIN_MOD8_ZERO = 3'h0;
	localparam logic [7:0] MAG_ZERO = 8'h00;
	localparam logic [7:0] MAG_ONE = 8'h01;

	// step size: ppm figures and the clock pulses per correction
	localparam real STEP_PPM_NORMAL = 2.170;
	localparam real STEP_PPM_FAST = 2.0345;
	localparam real OSC_HZ = 32768.0;
	localparam real PERIOD_S_NORMAL = 14400.0;
	localparam real PERIOD_S_FAST = 480.0;
	localparam logic [10:0] CLKS_NORMAL =
		11'(int'(STEP_PPM_NORMAL * 1.0e-6 * PERIOD_S_NORMAL * OSC_HZ));
	localparam logic [10:0] CLKS_FAST =
		11'(int'(STEP_PPM_FAST * 1.0e-6 * PERIOD_S_FAST * OSC_HZ));

	// 128 Hz ticks that end an irq pulse
	localparam logic [1:0] PULSE_TICKS = 2'h2;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [4:0] hour;
		logic [5:0] min;
		logic [5:0] sec;
	} oti_time_s;

	typedef enum logic {SEQ_IDLE, SEQ_RUN} oti_seq_e;
endpackage : oti_pkg

`default_nettype wire

// ===== oti_irq_pulse.sv
// one irq pulse generator: starts on an event, ends on 128 Hz ticks
// assumes tick_128 is a one-cycle strobe in the clk domain
`default_nettype none

module oti_irq_pulse
	import oti_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// event and timebase
	input wire logic event_in,
	input wire logic tick_128,
	// pulse out, active high
	output logic active_q
);
	logic [1:0] ticks_q;
	logic [1:0] ticks_d;
	logic active_d;

	// -----------------------------------------------------------------
	// pulse width control
	// -----------------------------------------------------------------
	// event restarts the count; second tick afterwards ends the pulse
	assign ticks_d = event_in ? 2'h0 : (active_q && tick_128) ? ticks_q + 2'h1 : ticks_q;
	assign active_d = event_in | (active_q & ~(tick_128 && ticks_d == PULSE_TICKS));

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			active_q <= 1'b0;
			ticks_q <= 2'h0;
		end else begin
			active_q <= active_d;
			ticks_q <= active_d ? ticks_d : 2'h0;
		end
	end

	// the second tick after the event ends the pulse
	pulse_width_a: assert property (@(posedge clk) disable iff (sys_rst)
		(active_q && tick_128 && !event_in && ticks_q == PULSE_TICKS - 2'h1) |=> !active_q)
		else $error("irq pulse outlived two ticks");
endmodule : oti_irq_pulse

`default_nettype wire

// ===== oti_trim_irq_tb.sv
// self-checking bench for the trim sequencer, register port and irq pins
// assumes oti_pkg is compiled first; the bench plays timekeeping and software
`default_nettype none

`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fails++; \
	$display("Error %0t: mismatch got %0h exp %0h", $time, (g), (e)); end end

module oti_trim_irq_tb
	import oti_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata_q;
	logic sec_tick = 1'b0;
	oti_time_s time_now = '0;
	logic tick_128 = 1'b0;
	logic corr_add_q, corr_sub_q;
	logic [10:0] corr_clocks_q;
	logic irq_out_a_o_q, irq_out_a_oe_n_q, stamp_pin_o_q, stamp_pin_oe_n_q, sys_irq_q;
	int fails = 0;
	int samples_checked = 0;
	int n_add, n_sub, lo_a, lo_b, cyc, tc;
	logic [10:0] clk_seen;
	logic [11:0] last_pos;
	logic [7:0] rst_addr [7] = '{8'h24, 8'h25, 8'h29, 8'h2a, 8'h30, 8'h31, 8'h32};

	// 40 MHz clock
	always #12.5 clk = ~clk;

	// free running 128 Hz tick, shortened to 64 cycles
	always @(posedge clk) begin
		tc <= (tc == 63) ? 0 : tc + 1;
		tick_128 <= (tc == 63);
	end

	oti_trim_irq dut_u (
		.clk(clk), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata_q(reg_rdata_q),
		.sec_tick(sec_tick), .time_now(time_now), .tick_128(tick_128),
		.corr_add_q(corr_add_q), .corr_sub_q(corr_sub_q), .corr_clocks_q(corr_clocks_q),
		.irq_out_a_o_q(irq_out_a_o_q), .irq_out_a_oe_n_q(irq_out_a_oe_n_q),
		.stamp_pin_o_q(stamp_pin_o_q), .stamp_pin_oe_n_q(stamp_pin_oe_n_q),
		.sys_irq_q(sys_irq_q)
	);

	// ----------------------------------------------------------------
	// monitors: correction pulses and asserted pin cycles
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		if (corr_add_q === 1'b1) begin
			n_add++;
			clk_seen = corr_clocks_q;
		end
		if (corr_sub_q === 1'b1) begin
			n_sub++;
			clk_seen = corr_clocks_q;
			last_pos = {time_now.min, time_now.sec};
		end
		if (irq_out_a_oe_n_q === 1'b0) lo_a++;
		if (stamp_pin_oe_n_q === 1'b0 && stamp_pin_o_q === 1'b0) lo_b++;
	end

	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			end_of_test();
		end
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata_q;
	endtask : rd

	// one second advance of the timekeeping counters
	task automatic tk(input logic [4:0] h, input logic [5:0] m, input logic [5:0] s);
		@(posedge clk);
		sec_tick <= 1'b1;
		time_now <= '{h, m, s};
		@(posedge clk);
		sec_tick <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : tk

	task automatic clr();
		#1;
		n_add = 0;
		n_sub = 0;
		lo_a = 0;
		lo_b = 0;
	endtask : clr

	task automatic end_of_test();
		$display("checks %0d fails %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_of_test

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [7:0] d;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		// reset values and idle pins
		foreach (rst_addr[i]) begin
			rd(rst_addr[i], d);
			`CHK(d, 8'h00)
		end
		`CHK(irq_out_a_oe_n_q, 1'b1)
		`CHK(stamp_pin_oe_n_q, 1'b1)
		// extreme trim readback, unmapped place
		wr(8'h24, 8'h80);
		rd(8'h24, d);
		`CHK(d, 8'h80)
		wr(8'h40, 8'hff);
		rd(8'h40, d);
		`CHK(d, 8'h00)
		// fast schedule, +2, irq on the open-drain pin only
		wr(8'h25, 8'h40);
		wr(8'h24, 8'h02);
		wr(8'h29, 8'h20);
		wr(8'h30, 8'h04);
		rd(8'h25, d);
		`CHK(d, 8'h40)
		clr();
		tk(5'h00, 6'h03, 6'h00);
		`CHK(n_add, 0)
		tk(5'h00, 6'h08, 6'h00);
		`CHK(n_add, 1)
		`CHK(clk_seen, 11'h020)
		repeat (200) @(posedge clk);
		`CHK(lo_a > 63 && lo_a < 132, 1'b1)
		`CHK(lo_b, 0)
		`CHK(irq_out_a_o_q, 1'b0)
		tk(5'h00, 6'h08, 6'h01);
		tk(5'h00, 6'h08, 6'h02);
		`CHK(n_add, 2)
		`CHK(n_sub, 0)
		// sticky status, mask and system interrupt
		rd(8'h31, d);
		`CHK(d, 8'h05)
		wr(8'h32, 8'h01);
		repeat (2) @(posedge clk);
		`CHK(sys_irq_q, 1'b1)
		wr(8'h31, 8'h07);
		repeat (2) @(posedge clk);
		`CHK(sys_irq_q, 1'b0)
		rd(8'h31, d);
		`CHK(d, 8'h00)
		wr(8'h32, 8'h00);
		// let the last irq a pulse die out before counting again
		repeat (200) @(posedge clk);
		// normal schedule, -1, irq on the stamp pin only
		wr(8'h25, 8'h00);
		wr(8'h24, 8'hff);
		wr(8'h29, 8'h00);
		wr(8'h2a, 8'h20);
		clr();
		tk(5'h01, 6'h00, 6'h00);
		`CHK(n_sub, 0)
		tk(5'h04, 6'h00, 6'h00);
		`CHK(n_sub, 1)
		`CHK(clk_seen, 11'h400)
		tk(5'h04, 6'h01, 6'h00);
		`CHK(n_sub, 1)
		repeat (200) @(posedge clk);
		`CHK(lo_b > 63 && lo_b < 132, 1'b1)
		`CHK(lo_a, 0)
		// fast schedule, -128, spills over three minutes
		wr(8'h25, 8'h40);
		wr(8'h24, 8'h80);
		wr(8'h2a, 8'h00);
		clr();
		for (int m = 16; m < 19; m++) begin
			for (int s = 0; s < 60; s++) tk(5'h00, 6'(m), 6'(s));
		end
		`CHK(n_sub, 128)
		`CHK(last_pos, {6'h12, 6'h07})
		// wrong pin mode keeps irq_out_a released, stamp pin not driven
		wr(8'h30, 8'h01);
		wr(8'h29, 8'h20);
		wr(8'h24, 8'h01);
		clr();
		tk(5'h00, 6'h20, 6'h00);
		repeat (200) @(posedge clk);
		`CHK(n_add, 1)
		`CHK(n_sub, 0)
		`CHK(lo_a, 0)
		`CHK(stamp_pin_oe_n_q, 1'b1)
		// zero trim gives no correction
		wr(8'h24, 8'h00);
		clr();
		tk(5'h00, 6'h18, 6'h00);
		tk(5'h00, 6'h18, 6'h01);
		`CHK(n_add + n_sub, 0)
		end_of_test();
	end
endmodule : oti_trim_irq_tb

`default_nettype wire
